/* logic/tsm_params.svh */
`ifndef TSM_PARAMS_SVH
`define TSM_PARAMS_SVH

// host address layout (word address, 15 bits)
`define TSM_ADDR_W          15
`define TSM_ADDR_MEM_BIT    14
`define TSM_DATA_W          16
`define TSM_LOC_W           14
`define TSM_STORE_IDX_W     13
`define TSM_STORE_DEPTH     8192

// register offsets inside register space (address bit 14 low)
`define TSM_OFS_CONTROL     14'h0000
`define TSM_OFS_STATUS      14'h0001

// control register fields
`define TSM_CTL_SEL_LSB     0
`define TSM_CTL_LRATE_LSB   3
`define TSM_CTL_BRATE_LSB   6
`define TSM_CTL_USED_W      9
`define TSM_CTL_RESET       9'h000

// status register fields
`define TSM_STS_OVF_LSB     0
`define TSM_STS_PEND_LSB    2

// memory select codes
`define TSM_SEL_LOCAL_ROUTE 3'h0
`define TSM_SEL_BACK_ROUTE  3'h1
`define TSM_SEL_LOCAL_RX    3'h2
`define TSM_SEL_BACK_RX     3'h3

// rate codes: channels per stream are 32 shifted left by the code, codes above 4 counting as 4
`define TSM_RATE_TOP        3'h4
`define TSM_CHAN_BASE       10'h020
`define TSM_STREAMS_LOW     5'h1F
`define TSM_STREAMS_TOP     5'h0F

// receive buffering
`define TSM_FIFO_DEPTH      4

`endif

/* logic/tsm_pkg.sv */
package tsm_pkg;

    // which memory a host memory-space access reaches
    typedef enum logic [2:0]
    {
        TSM_TGT_LOCAL_ROUTE = 3'h0,
        TSM_TGT_BACK_ROUTE  = 3'h1,
        TSM_TGT_LOCAL_RX    = 3'h2,
        TSM_TGT_BACK_RX     = 3'h3,
        TSM_TGT_NONE        = 3'h4
    } tsm_target_e;

    // bus answer sequencing
    typedef enum logic
    {
        TSM_BUS_IDLE   = 1'b0,
        TSM_BUS_ANSWER = 1'b1
    } tsm_bus_e;

    // one received timeslot on its way to a data store
    typedef struct packed
    {
        logic [12:0] idx;
        logic [7:0]  data;
    } tsm_rx_word_s;

    // raw serial pins of one input side
    typedef struct packed
    {
        logic frame;
        logic strobe;
        logic bit_val;
    } tsm_pins_s;

endpackage

/* logic/tsm_switch_mem.sv */
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "tsm_params.svh"

// small synchronous fifo with valid/ready on both sides
module tsm_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = `TSM_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             sys_rst_in,
    // filling side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // draining side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] slots [DEPTH];  // storage
    logic [PW-1:0]    wr_ptr;         // next slot to fill
    logic [PW-1:0]    rd_ptr;         // next slot to drain
    logic [PW:0]      count;          // words held
    logic             push;
    logic             pop;

    // full and empty come straight from the count
    assign in_ready_out  = (count < (PW+1)'(DEPTH));  // room while below depth
    assign out_valid_out = (count != '0);
    assign out_data_out  = slots[rd_ptr];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // storage is not reset; only pointers and count define what is valid
    always_ff @(posedge core_clk_in)
    begin
        if (push)
        begin
            slots[wr_ptr] <= in_data_in;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// Notes on behaviour
// - address bit 14 picks memory over registers
// - memory select field picks among four memories
// - select 000 local, 001 backplane route store
// - low fourteen address bits give location
// - bits 13:9 are stream; 0-15 at top rate
// - bits 8:0 are channel, 0 to 511 at top rate
// - channels per stream follow the stream rate
// - separate local and backplane receive stores
// - each timeslot becomes a byte, stored in sequence
// - local receive store: 8192 bytes by stream/channel
// - local receive store is read-only to host
// - backplane receive store: 8192 bytes by stream/channel
// - backplane receive store is read-only to host
// - receive store reads zero bits 15:8
// - first received bit lands in byte bit 7
module tsm_switch_mem
    import tsm_pkg::*;
(
    // clock and reset
    input  wire logic                     core_clk_in,
    input  wire logic                     sys_rst_in,
    // avalon-mm slave
    input  wire logic [`TSM_ADDR_W-1:0]   avs_address_in,
    input  wire logic                     avs_read_in,
    input  wire logic                     avs_write_in,
    input  wire logic [`TSM_DATA_W-1:0]   avs_writedata_in,
    input  wire logic [1:0]               avs_byteenable_in,
    output logic [`TSM_DATA_W-1:0]        avs_readdata_out,
    output logic                          avs_waitrequest_out,
    // serial inputs, index 0 local side, index 1 backplane side
    input  wire tsm_pkg::tsm_pins_s [1:0] rx_pins_in
);
    import tsm_pkg::*;

    // which memory a select code reaches
    function automatic tsm_target_e target_of(input logic [2:0] sel);
        tsm_target_e t;
        t = TSM_TGT_NONE;
        unique case (sel)
            `TSM_SEL_LOCAL_ROUTE: t = TSM_TGT_LOCAL_ROUTE;
            `TSM_SEL_BACK_ROUTE:  t = TSM_TGT_BACK_ROUTE;
            `TSM_SEL_LOCAL_RX:    t = TSM_TGT_LOCAL_RX;
            `TSM_SEL_BACK_RX:     t = TSM_TGT_BACK_RX;
            default:              t = TSM_TGT_NONE;
        endcase
        return t;
    endfunction

    // fold stream and channel into 8192 entries: at the top rate stream bit 4
    // is unused, below it channel bit 8 is unused
    function automatic logic [`TSM_STORE_IDX_W-1:0] fold_idx(input logic [2:0] rate,
                                                            input logic [4:0] strm,
                                                            input logic [8:0] chan);
        logic [`TSM_STORE_IDX_W-1:0] r;
        r = '0;
        if (rate >= `TSM_RATE_TOP)
        begin
            r = {strm[3:0], chan};
        end
        else
        begin
            r = {strm, chan[7:0]};
        end
        return r;
    endfunction

    // last channel number of a stream at a rate
    function automatic logic [8:0] chan_last(input logic [2:0] rate);
        logic [2:0] r;
        r = (rate > `TSM_RATE_TOP) ? `TSM_RATE_TOP : rate;
        return 9'(({1'b0, `TSM_CHAN_BASE} << r) - 11'h001);
    endfunction

    // control register and its fields
    logic [`TSM_CTL_USED_W-1:0] control;
    logic [2:0]                 memory_select;
    logic [2:0]                 rate [2];
    // sticky overflow per side
    logic [1:0]                 rx_overflow;
    // bus sequencing and answer
    tsm_bus_e                   bus_state;
    logic [`TSM_DATA_W-1:0]     rd_data;
    // decoded request
    logic                       req;
    logic                       is_mem;
    logic [`TSM_LOC_W-1:0]      loc;
    tsm_target_e                tgt;
    logic                       take;
    logic                       wr_take;
    logic [2:0]                 tgt_rate;
    logic [`TSM_STORE_IDX_W-1:0] host_idx;
    // memories
    logic [15:0] local_route_store     [`TSM_STORE_DEPTH];
    logic [15:0] backplane_route_store [`TSM_STORE_DEPTH];
    logic [7:0]  local_rx_byte_store     [`TSM_STORE_DEPTH];
    logic [7:0]  backplane_rx_byte_store [`TSM_STORE_DEPTH];
    // receive path per side
    tsm_pins_s    pin_meta [2];
    tsm_pins_s    pin_sync [2];
    tsm_pins_s    pin_prev [2];
    logic [2:0]   bit_cnt  [2];
    logic [6:0]   shift    [2];
    logic [4:0]   strm_cnt [2];
    logic [8:0]   chan_cnt [2];
    logic [1:0]   push_valid;
    logic [1:0]   push_ready;
    tsm_rx_word_s push_word [2];
    logic [1:0]   drain_valid;
    logic [1:0]   drain_ready;
    tsm_rx_word_s drain_word [2];
    logic [1:0]   host_rx_read;

    assign memory_select = control[`TSM_CTL_SEL_LSB +: 3];
    assign rate[0]       = control[`TSM_CTL_LRATE_LSB +: 3];
    assign rate[1]       = control[`TSM_CTL_BRATE_LSB +: 3];

    // request decode
    assign req      = avs_read_in || avs_write_in;
    assign is_mem   = avs_address_in[`TSM_ADDR_MEM_BIT];
    assign loc      = avs_address_in[`TSM_LOC_W-1:0];
    assign tgt      = target_of(memory_select);
    assign take     = req && (bus_state == TSM_BUS_ANSWER);
    assign wr_take  = take && avs_write_in;
    assign tgt_rate = ((tgt == TSM_TGT_LOCAL_ROUTE) || (tgt == TSM_TGT_LOCAL_RX)) ? rate[0] : rate[1];
    assign host_idx = fold_idx(tgt_rate, loc[13:9], loc[8:0]);

    // one wait state on every access; answer in the second cycle
    assign avs_waitrequest_out = req && (bus_state == TSM_BUS_IDLE);
    assign avs_readdata_out    = rd_data;

    // receive store read ports are busy while the host samples them,
    // so the draining fifo stalls for that cycle
    assign host_rx_read[0] = avs_read_in && is_mem && (bus_state == TSM_BUS_IDLE) && (tgt == TSM_TGT_LOCAL_RX);
    assign host_rx_read[1] = avs_read_in && is_mem && (bus_state == TSM_BUS_IDLE) && (tgt == TSM_TGT_BACK_RX);

    // bus state: idle sees request, answer releases it
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            bus_state <= TSM_BUS_IDLE;
        end
        else
        begin
            unique case (bus_state)
                TSM_BUS_IDLE:
                begin
                    if (req)
                    begin
                        bus_state <= TSM_BUS_ANSWER;
                    end
                end
                TSM_BUS_ANSWER:
                begin
                    bus_state <= TSM_BUS_IDLE;
                end
            endcase
        end
    end

    // read data captured in the wait cycle, stands through the answer
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            rd_data <= '0;
        end
        else if (avs_read_in && (bus_state == TSM_BUS_IDLE))
        begin
            rd_data <= '0;
            if (is_mem)
            begin
                unique case (tgt)
                    TSM_TGT_LOCAL_ROUTE: rd_data <= local_route_store[host_idx];
                    TSM_TGT_BACK_ROUTE:  rd_data <= backplane_route_store[host_idx];
                    TSM_TGT_LOCAL_RX:    rd_data <= {8'h00, local_rx_byte_store[host_idx]};
                    TSM_TGT_BACK_RX:     rd_data <= {8'h00, backplane_rx_byte_store[host_idx]};
                    TSM_TGT_NONE:        rd_data <= '0;
                endcase
            end
            else if (loc == `TSM_OFS_CONTROL)
            begin
                rd_data <= {{(`TSM_DATA_W - `TSM_CTL_USED_W){1'b0}}, control};
            end
            else if (loc == `TSM_OFS_STATUS)
            begin
                rd_data <= {12'h000, drain_valid, rx_overflow};
            end
        end
    end

    // control register, byte-lane writes; unmapped offsets ignore writes
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            control <= `TSM_CTL_RESET;
        end
        else if (wr_take && !is_mem && (loc == `TSM_OFS_CONTROL))
        begin
            if (avs_byteenable_in[0])
            begin
                control[7:0] <= avs_writedata_in[7:0];
            end
            if (avs_byteenable_in[1])
            begin
                control[8] <= avs_writedata_in[8];
            end
        end
    end

    // overflow flags: write one to clear, a new overflow wins the same cycle
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            rx_overflow <= '0;
        end
        else
        begin
            for (int s = 0; s < 2; s++)
            begin
                if (push_valid[s] && !push_ready[s])
                begin
                    rx_overflow[s] <= 1'b1;
                end
                else if (wr_take && !is_mem && (loc == `TSM_OFS_STATUS) && avs_byteenable_in[0]
                         && avs_writedata_in[`TSM_STS_OVF_LSB + s])
                begin
                    rx_overflow[s] <= 1'b0;
                end
            end
        end
    end

    // route stores: host read/write with byte lanes
    always_ff @(posedge core_clk_in)
    begin
        if (wr_take && is_mem && (tgt == TSM_TGT_LOCAL_ROUTE))
        begin
            if (avs_byteenable_in[0])
            begin
                local_route_store[host_idx][7:0] <= avs_writedata_in[7:0];
            end
            if (avs_byteenable_in[1])
            begin
                local_route_store[host_idx][15:8] <= avs_writedata_in[15:8];
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (wr_take && is_mem && (tgt == TSM_TGT_BACK_ROUTE))
        begin
            if (avs_byteenable_in[0])
            begin
                backplane_route_store[host_idx][7:0] <= avs_writedata_in[7:0];
            end
            if (avs_byteenable_in[1])
            begin
                backplane_route_store[host_idx][15:8] <= avs_writedata_in[15:8];
            end
        end
    end

    // receive stores: written only by the receivers, host writes just ack
    always_ff @(posedge core_clk_in)
    begin
        if (drain_valid[0] && drain_ready[0])
        begin
            local_rx_byte_store[drain_word[0].idx] <= drain_word[0].data;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (drain_valid[1] && drain_ready[1])
        begin
            backplane_rx_byte_store[drain_word[1].idx] <= drain_word[1].data;
        end
    end

    // one receiver and one fifo per side
    for (genvar s = 0; s < 2; s++)
    begin : g_side
        logic strobe_rise;
        logic frame_rise;
        logic [4:0] strm_last;

        assign strobe_rise = pin_sync[s].strobe && !pin_prev[s].strobe;
        assign frame_rise  = pin_sync[s].frame && !pin_prev[s].frame;
        assign strm_last   = (rate[s] >= `TSM_RATE_TOP) ? `TSM_STREAMS_TOP : `TSM_STREAMS_LOW;

        // two flops on the pins; edges are seen only on the second
        always_ff @(posedge core_clk_in or posedge sys_rst_in)
        begin
            if (sys_rst_in)
            begin
                pin_meta[s] <= '0;
                pin_sync[s] <= '0;
                pin_prev[s] <= '0;
            end
            else
            begin
                pin_meta[s] <= rx_pins_in[s];
                pin_sync[s] <= pin_meta[s];
                pin_prev[s] <= pin_sync[s];
            end
        end

        // the eighth bit completes a byte; first bit ends up in bit 7
        assign push_valid[s]     = strobe_rise && (frame_rise || bit_cnt[s] == 3'h7) && !frame_rise;
        assign push_word[s].data = {shift[s], pin_sync[s].bit_val};
        assign push_word[s].idx  = fold_idx(rate[s], strm_cnt[s], chan_cnt[s]);

        // bit, stream and channel counting; frame pulse restarts the frame
        always_ff @(posedge core_clk_in or posedge sys_rst_in)
        begin
            if (sys_rst_in)
            begin
                bit_cnt[s]  <= '0;
                shift[s]    <= '0;
                strm_cnt[s] <= '0;
                chan_cnt[s] <= '0;
            end
            else if (frame_rise)
            begin
                // a strobe on the frame edge is the first bit of the frame
                bit_cnt[s]  <= strobe_rise ? 3'h1 : 3'h0;
                shift[s]    <= {6'h00, pin_sync[s].bit_val & strobe_rise};
                strm_cnt[s] <= '0;
                chan_cnt[s] <= '0;
            end
            else if (strobe_rise)
            begin
                bit_cnt[s] <= bit_cnt[s] + 3'h1;
                shift[s]   <= {shift[s][5:0], pin_sync[s].bit_val};
                if (bit_cnt[s] == 3'h7)
                begin
                    // streams interleave within each channel time
                    if (strm_cnt[s] >= strm_last)
                    begin
                        strm_cnt[s] <= '0;
                        chan_cnt[s] <= (chan_cnt[s] >= chan_last(rate[s])) ? 9'h000 : chan_cnt[s] + 9'h001;
                    end
                    else
                    begin
                        strm_cnt[s] <= strm_cnt[s] + 5'h01;
                    end
                end
            end
        end

        // drain stalls while the host samples this store
        assign drain_ready[s] = !host_rx_read[s];

        // a full fifo drops the byte and raises the overflow flag
        tsm_fifo #(
            .WIDTH ($bits(tsm_rx_word_s)),
            .DEPTH (`TSM_FIFO_DEPTH)
        ) u_fifo (
            .core_clk_in   (core_clk_in),
            .sys_rst_in    (sys_rst_in),
            .in_valid_in   (push_valid[s]),
            .in_ready_out  (push_ready[s]),
            .in_data_in    (push_word[s]),
            .out_valid_out (drain_valid[s]),
            .out_ready_in  (drain_ready[s]),
            .out_data_out  (drain_word[s])
        );
    end
endmodule

/* dv/tsm_switch_mem_properties.sv */
`timescale 1ns/1ps

// host port watch: wait states, readback, zero fills
module tsm_switch_mem_checker (
    // clock and reset
    input wire logic        core_clk_in,
    input wire logic        sys_rst_in,
    // avalon-mm slave side
    input wire logic [14:0] avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [15:0] avs_writedata_in,
    input wire logic [1:0]  avs_byteenable_in,
    input wire logic [15:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out
);
    logic [8:0] ctl; // shadow of the control word
    logic       req; // a transfer is requested
    logic       fin; // transfer completes at this edge
    logic       rdm; // completing read of memory space
    assign req = avs_read_in | avs_write_in;
    assign fin = req & ~avs_waitrequest_out;
    assign rdm = fin & avs_read_in & avs_address_in[14];
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    // shadow follows completed control writes lane by lane
    always_ff @(posedge core_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ctl <= 9'h000;
        else if (fin && avs_write_in && avs_address_in == 15'h0000)
        begin
            if (avs_byteenable_in[0])
                ctl[7:0] <= avs_writedata_in[7:0];
            if (avs_byteenable_in[1])
                ctl[8] <= avs_writedata_in[8];
        end
    end
    AST_WAIT_FIRST: assert property ($rose(req) |-> avs_waitrequest_out)
        else $error("new request got no wait state");
    AST_ONE_WAIT: assert property (req && avs_waitrequest_out ##1 req |-> !avs_waitrequest_out)
        else $error("more than one wait state");
    AST_IDLE_NOWAIT: assert property (!req |-> !avs_waitrequest_out)
        else $error("wait asserted while idle");
    AST_RX_UPPER_ZERO: assert property (rdm && ctl[2:1] == 2'h1 |-> avs_readdata_out[15:8] == 8'h00)
        else $error("receive store read upper byte not zero");
    AST_SEL_HOLE_ZERO: assert property (rdm && ctl[2] |-> avs_readdata_out == 16'h0000)
        else $error("unmapped select read not zero");
    AST_CTL_READBACK: assert property (fin && avs_read_in && avs_address_in == 15'h0000
        |-> avs_readdata_out[8:0] == ctl)
        else $error("control readback wrong");
    AST_REG_HOLE_ZERO: assert property (fin && avs_read_in && !avs_address_in[14]
        && avs_address_in[13:1] != 13'h0000 |-> avs_readdata_out == 16'h0000)
        else $error("unmapped register read not zero");
    AST_RDATA_HOLD: assert property (!(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out))
        else $error("read data moved without a read");
    // main scenarios reached
    CVR_RX_READ: cover property (rdm && ctl[2:0] == 3'h2);
    CVR_ROUTE_WRITE: cover property (fin && avs_write_in && avs_address_in[14] && ctl[2:0] == 3'h1);
    CVR_REG_HOLE: cover property (fin && avs_read_in && avs_address_in == 15'h0002);
endmodule

bind tsm_switch_mem tsm_switch_mem_checker tsm_switch_mem_checker_inst (
    .core_clk_in        (core_clk_in),
    .sys_rst_in         (sys_rst_in),
    .avs_address_in     (avs_address_in),
    .avs_read_in        (avs_read_in),
    .avs_write_in       (avs_write_in),
    .avs_writedata_in   (avs_writedata_in),
    .avs_byteenable_in  (avs_byteenable_in),
    .avs_readdata_out   (avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out)
);

/* dv/tsm_rx_source.sv */
`timescale 1ns/1ps

// serial timeslot source for both input sides
module tsm_rx_source
    import tsm_pkg::*;
(
    // clock
    input  wire logic                core_clk_in,
    // pins, index 0 local, 1 backplane
    output tsm_pkg::tsm_pins_s [1:0] pins_out
);
    // strobes stand still outside frames
    initial pins_out = '0;
    // one frame: frame pulse, then each byte first bit first
    task automatic send(input int side, input logic [7:0] b [3]);
        @(posedge core_clk_in);
        pins_out[side].frame <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        pins_out[side].frame <= 1'b0;
        foreach (b[k])
            for (int i = 7; i >= 0; i--)
            begin
                // data settles a cycle before its strobe rises
                pins_out[side].bit_val <= b[k][i];
                @(posedge core_clk_in);
                pins_out[side].strobe <= 1'b1;
                repeat (2) @(posedge core_clk_in);
                pins_out[side].strobe <= 1'b0;
                @(posedge core_clk_in);
            end
        // released line must not keep showing the last bit
        pins_out[side].bit_val <= ~pins_out[side].bit_val;
    endtask
endmodule

/* dv/test_tsm_switch_mem.sv */
`timescale 1ns/1ps

// host access bench over avalon-mm
module test_tsm_switch_mem;
    import tsm_pkg::*;
    logic                     clk;         // 50 MHz
    logic                     rst;         // async, high
    logic [14:0]              addr;        // word address
    logic                     rd;          // read request
    logic                     wr;          // write request
    logic [15:0]              wdata;       // write data
    logic [1:0]               be;          // lane enables
    logic [15:0]              rdata;       // read data
    logic                     wq;          // waitrequest
    tsm_pkg::tsm_pins_s [1:0] pins;        // serial inputs
    logic [15:0]              d;           // last read word
    int                       miscompares; // mismatches
    int                       checks;      // comparisons
    int                       cyc = 0;     // timeout count
    logic [14:0]              at [4];      // table addresses
    logic [15:0]              vt [4];      // table values
    logic [7:0]               lb [3];      // local bytes
    logic [7:0]               bb [3];      // backplane bytes

    tsm_switch_mem tsm_switch_mem_inst (
        .core_clk_in        (clk),
        .sys_rst_in         (rst),
        .avs_address_in     (addr),
        .avs_read_in        (rd),
        .avs_write_in       (wr),
        .avs_writedata_in   (wdata),
        .avs_byteenable_in  (be),
        .avs_readdata_out   (rdata),
        .avs_waitrequest_out(wq),
        .rx_pins_in         (pins)
    );
    tsm_rx_source tsm_rx_source_inst (
        .core_clk_in(clk),
        .pins_out   (pins)
    );

    // clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // memory-space address of a stream and channel
    function automatic logic [14:0] ma(input logic [4:0] s, input logic [8:0] c);
        return {1'b1, s, c};
    endfunction

    // verdict and end of run
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // compare one word
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask

    // one transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [14:0] a, input logic [15:0] wd, output logic [15:0] q);
        @(posedge clk);
        addr <= a;
        wdata <= wd;
        wr <= w;
        rd <= !w;
        // waitrequest is judged at a rising edge; data is taken at that edge
        do
            @(posedge clk);
        while (wq);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // control word write
    task automatic wrc(input logic [8:0] v);
        bus(1'b1, 15'h0000, {7'h00, v}, d);
    endtask

    // write the whole table, then read it all back
    task automatic fill_check();
        for (int k = 0; k < 4; k++)
            bus(1'b1, at[k], vt[k], d);
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b0, at[k], 16'h0000, d);
            check(d, vt[k]);
        end
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            miscompares++;
            test_done();
        end
    end

    initial
    begin
        rst = 1'b1;
        addr = '0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = '0;
        be = 2'h3;
        miscompares = 0;
        checks = 0;
        lb = '{8'h96, 8'h3C, 8'hE1};
        bb = '{8'h5A, 8'h81, 8'h7E};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 15'h0000, 16'h0000, d);
        check({7'h00, d[8:0]}, 16'h0000);
        // rate 0 local route store: corners stay apart
        at = '{ma(0, 0), ma(31, 31), ma(3, 5), ma(16, 0)};
        vt = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
        fill_check();
        // backplane route store, register versus memory space
        wrc(9'h001);
        bus(1'b1, ma(3, 5), 16'h5A3C, d);
        bus(1'b1, 15'h4000, 16'h00F0, d);
        bus(1'b0, 15'h0000, 16'h0000, d);
        check({7'h00, d[8:0]}, 16'h0001);
        bus(1'b0, ma(3, 5), 16'h0000, d);
        check(d, 16'h5A3C);
        wrc(9'h000);
        bus(1'b0, ma(3, 5), 16'h0000, d);
        check(d, 16'h3333);
        // local side at top rate: channel bit 8 counts
        wrc(9'h020);
        at = '{ma(0, 0), ma(0, 256), ma(15, 511), ma(8, 1)};
        vt = '{16'hC001, 16'hC100, 16'hC1FF, 16'hC008};
        fill_check();
        // one frame on each side, then both stores read
        wrc(9'h000);
        tsm_rx_source_inst.send(0, lb);
        tsm_rx_source_inst.send(1, bb);
        repeat (10) @(posedge clk);
        // every byte stored: no overflow, both fifos drained
        bus(1'b0, 15'h0001, 16'h0000, d);
        check(d, 16'h0000);
        wrc(9'h002);
        for (int k = 0; k < 3; k++)
        begin
            bus(1'b0, ma(k[4:0], 0), 16'h0000, d);
            check(d, {8'h00, lb[k]});
        end
        wrc(9'h003);
        for (int k = 0; k < 3; k++)
        begin
            bus(1'b0, ma(k[4:0], 0), 16'h0000, d);
            check(d, {8'h00, bb[k]});
        end
        // writes to receive stores finish and change nothing
        bus(1'b1, ma(1, 0), 16'hFFFF, d);
        bus(1'b0, ma(1, 0), 16'h0000, d);
        check(d, {8'h00, bb[1]});
        wrc(9'h002);
        bus(1'b1, ma(1, 0), 16'hFFFF, d);
        bus(1'b0, ma(1, 0), 16'h0000, d);
        check(d, {8'h00, lb[1]});
        // unmapped select and register hole read zero
        wrc(9'h005);
        bus(1'b0, ma(1, 0), 16'h0000, d);
        check(d, 16'h0000);
        bus(1'b0, 15'h0002, 16'h0000, d);
        check(d, 16'h0000);
        test_done();
    end
endmodule
